/* hw/pgd_pkg.sv */
// Constants, register map and types for the power-good delay and rail disable block.
// Assumes one 40 MHz system clock and a synchronous active-high reset.
//
// Functional notes
// - Output two delay code at bits 7:5 selects 0 to 100 ms.
// - Output four delay code at bits 4:2 uses the same code table.
// - Output one delay code at bits 1:0 selects 0, 5, 10 or 15 ms.
// - Delay starts once all grouped rails regulate; power good follows its expiry.
// - Generated delays stay within ten percent of nominal for every code.
// - Host-driven output two ignores its delay unless it enables termination.
// - Host-driven output four or one ignores its delay field.
// - Each pin is power good, level shifter or host output by strap.
// - Bit 7 low forces the strap-chosen shared rail off; high lets its request or force-on bit enable it.
// - Bit 6 low forces the first B load switch off.
// - Bit 5 low forces the first A load switch off.
// - Bit 4 low forces the memory termination regulator off.
// - A force-on bit turns a rail on unless its off bit is zero.

package pgd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = (TICK_US * CLK_HZ) / 1_000_000;
   localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);

   localparam int DLY_US_0 = 0;
   localparam int DLY_US_5 = 5_000;
   localparam int DLY_US_10 = 10_000;
   localparam int DLY_US_15 = 15_000;
   localparam int DLY_US_20 = 20_000;
   localparam int DLY_US_50 = 50_000;
   localparam int DLY_US_100 = 100_000;

   // Delay in timer ticks for a 3-bit code
   function automatic logic [9:0] pgd_delay_ticks(input logic [2:0] code);
      logic [9:0] t;
      t = 10'h000;
      case (code)
         3'h0: t = 10'(DLY_US_0 / TICK_US);
         3'h1: t = 10'(DLY_US_5 / TICK_US);
         3'h2: t = 10'(DLY_US_10 / TICK_US);
         3'h3: t = 10'(DLY_US_15 / TICK_US);
         3'h4: t = 10'(DLY_US_20 / TICK_US);
         3'h5: t = 10'(DLY_US_50 / TICK_US);
         default: t = 10'(DLY_US_100 / TICK_US);
      endcase
      return t;
   endfunction : pgd_delay_ticks

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] OFF_GOOD_DELAY = 8'h9d;
   localparam logic [7:0] OFF_RAIL_OFF = 8'h9f;
   localparam logic [7:0] RST_GOOD_DELAY = 8'h00;
   localparam logic [7:0] RST_RAIL_OFF = 8'hf0;

   localparam int TWO_DLY_MSB = 7;
   localparam int TWO_DLY_LSB = 5;
   localparam int FOUR_DLY_MSB = 4;
   localparam int FOUR_DLY_LSB = 2;
   localparam int ONE_DLY_MSB = 1;
   localparam int ONE_DLY_LSB = 0;
   localparam int SHARED_OFF_BIT = 7;
   localparam int FIRST_B_OFF_BIT = 6;
   localparam int FIRST_A_OFF_BIT = 5;
   localparam int TERM_OFF_BIT = 4;

   // Arbitrary default bus address
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5e;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      PGD_MODE_GOOD = 2'b00,
      PGD_MODE_SHIFT = 2'b01,
      PGD_MODE_HOST = 2'b10
   } pgd_mode_t;

   typedef enum logic [3:0] {
      PGD_ST_IDLE = 4'b0000,
      PGD_ST_ADDR = 4'b0001,
      PGD_ST_ADDR_ACK = 4'b0010,
      PGD_ST_PTR = 4'b0011,
      PGD_ST_PTR_ACK = 4'b0100,
      PGD_ST_WR = 4'b0101,
      PGD_ST_WR_ACK = 4'b0110,
      PGD_ST_RD = 4'b0111,
      PGD_ST_RD_ACK = 4'b1000
   } pgd_i2c_st_t;

endpackage : pgd_pkg

/* hw/pgd_delay_timer.sv */
// One power-good delay timer for a single output pin.
// Assumes a tick pulse every TICK_US from the shared divider and synced inputs.
`timescale 1ns/1ps

module pgd_delay_timer
   import pgd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic tick,
   input wire logic start_ok,
   input wire logic [2:0] code,
   output logic good
);

   logic [9:0] count_q;
   logic [9:0] count_d;
   logic good_q;
   logic good_d;
   logic [9:0] target;

   // Tick phase is unknown, so the delay runs short by up to one tick (2% at 5 ms)
   assign target = pgd_delay_ticks(code);

   always_comb begin
      count_d = count_q;
      good_d = good_q;
      if (!start_ok) begin
         count_d = 10'h000;
         good_d = 1'b0;
      end else if (count_q >= target) begin
         good_d = 1'b1;
      end else if (tick) begin
         count_d = count_q + 10'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_q <= 10'h000;
         good_q <= 1'b0;
      end else begin
         count_q <= count_d;
         good_q <= good_d;
      end
   end

   assign good = good_q;

endmodule : pgd_delay_timer

/* hw/pgd_top.sv */
// Power-good delay and rail disable registers behind a two-wire serial slave.
// Assumes straps and neighbour-register bits are static or on clk_sys; pins are async.
`timescale 1ns/1ps

module pgd_top
   import pgd_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [7:0] rail_in_reg,
   input wire logic [7:0] group_mask_one,
   input wire logic [7:0] group_mask_two,
   input wire logic [7:0] group_mask_four,
   input wire logic [2:0] shifter_in,
   input wire logic [1:0] mode_one,
   input wire logic [1:0] mode_two,
   input wire logic [1:0] mode_four,
   input wire logic [2:0] host_level,
   input wire logic two_drives_termination,
   input wire logic shared_selects_linear,
   input wire logic [3:0] rail_request,
   input wire logic [3:0] rail_force_on,
   output logic general_output_one,
   output logic general_output_two,
   output logic general_output_four,
   output logic second_b_load_switch_en,
   output logic first_a_linear_regulator_en,
   output logic first_b_load_switch_en,
   output logic first_a_load_switch_en,
   output logic memory_termination_regulator_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops each
   logic [12:0] meta_q;
   logic [12:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic [7:0] rail_s;
   logic [2:0] shift_s;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // Rails read as out of regulation until sampled, so no false power good
         meta_q <= 13'h1800;
         sync_q <= 13'h1800;
      end else begin
         meta_q <= {scl_in, sda_in, shifter_in, rail_in_reg};
         sync_q <= meta_q;
      end
   end

   assign scl_s = sync_q[12];
   assign sda_s = sync_q[11];
   assign shift_s = sync_q[10:8];
   assign rail_s = sync_q[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave
   pgd_i2c_st_t st_q;
   pgd_i2c_st_t st_d;
   logic scl_p_q;
   logic sda_p_q;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [7:0] ptr_q;
   logic [7:0] ptr_d;
   logic oe_q;
   logic oe_d;
   logic nack_q;
   logic nack_d;
   logic [7:0] dly_q;
   logic [7:0] dly_d;
   logic [7:0] off_q;
   logic [7:0] off_d;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [7:0] rdata;

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_seen = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // Unmapped addresses read as zero and ignore writes
   always_comb begin
      if (ptr_q == OFF_GOOD_DELAY) begin
         rdata = dly_q;
      end else if (ptr_q == OFF_RAIL_OFF) begin
         rdata = off_q;
      end else begin
         rdata = 8'h00;
      end
   end

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      nack_d = nack_q;
      dly_d = dly_q;
      off_d = off_q;
      if (start_seen) begin
         st_d = PGD_ST_ADDR;
         bit_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop_seen) begin
         st_d = PGD_ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            PGD_ST_ADDR, PGD_ST_PTR, PGD_ST_WR: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s};
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  oe_d = 1'b1;
                  if (st_q == PGD_ST_ADDR) begin
                     if (sh_q[7:1] == DEV_ADDR) begin
                        st_d = PGD_ST_ADDR_ACK;
                        nack_d = sh_q[0];
                     end else begin
                        st_d = PGD_ST_IDLE;
                        oe_d = 1'b0;
                     end
                  end else if (st_q == PGD_ST_PTR) begin
                     ptr_d = sh_q;
                     st_d = PGD_ST_PTR_ACK;
                  end else begin
                     if (ptr_q == OFF_GOOD_DELAY) begin
                        dly_d = sh_q;
                     end else if (ptr_q == OFF_RAIL_OFF) begin
                        // Reserved low bits kept as written; host keeps them zero
                        off_d = sh_q;
                     end
                     ptr_d = ptr_q + 8'h01;
                     st_d = PGD_ST_WR_ACK;
                  end
               end
            end
            PGD_ST_ADDR_ACK, PGD_ST_PTR_ACK, PGD_ST_WR_ACK: begin
               if (scl_fall) begin
                  bit_d = 4'h0;
                  oe_d = 1'b0;
                  if (st_q == PGD_ST_ADDR_ACK && nack_q) begin
                     // Read direction: present first data bit now
                     sh_d = {rdata[6:0], 1'b0};
                     oe_d = ~rdata[7];
                     st_d = PGD_ST_RD;
                  end else if (st_q == PGD_ST_ADDR_ACK) begin
                     st_d = PGD_ST_PTR;
                  end else begin
                     st_d = PGD_ST_WR;
                  end
               end
            end
            PGD_ST_RD: begin
               if (scl_rise) begin
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall) begin
                  if (bit_q == 4'h8) begin
                     oe_d = 1'b0;
                     st_d = PGD_ST_RD_ACK;
                  end else begin
                     oe_d = ~sh_q[7];
                     sh_d = {sh_q[6:0], 1'b0};
                  end
               end
            end
            PGD_ST_RD_ACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     st_d = PGD_ST_IDLE;
                  end else begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end else if (scl_fall) begin
                  bit_d = 4'h0;
                  sh_d = {rdata[6:0], 1'b0};
                  oe_d = ~rdata[7];
                  st_d = PGD_ST_RD;
               end
            end
            default: begin
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= PGD_ST_IDLE;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         oe_q <= 1'b0;
         nack_q <= 1'b0;
         dly_q <= RST_GOOD_DELAY;
         off_q <= RST_RAIL_OFF;
      end else begin
         st_q <= st_d;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         bit_q <= bit_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         nack_q <= nack_d;
         dly_q <= dly_d;
         off_q <= off_d;
      end
   end

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Tick divider
   logic [11:0] div_q;
   logic [11:0] div_d;
   logic tick;

   assign tick = (div_q == TICK_LAST);

   always_comb begin
      div_d = tick ? 12'h000 : div_q + 12'h001;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q <= 12'h000;
      end else begin
         div_q <= div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-good delay per pin
   logic [2:0] start_ok;
   logic [2:0] timer_good;
   logic [2:0] run;
   logic [1:0] mode [3];
   logic [7:0] mask [3];
   logic [2:0] code [3];

   assign mode[0] = mode_one;
   assign mode[1] = mode_two;
   assign mode[2] = mode_four;
   assign mask[0] = group_mask_one;
   assign mask[1] = group_mask_two;
   assign mask[2] = group_mask_four;
   assign code[0] = {1'b0, dly_q[ONE_DLY_MSB:ONE_DLY_LSB]};
   assign code[1] = dly_q[TWO_DLY_MSB:TWO_DLY_LSB];
   assign code[2] = dly_q[FOUR_DLY_MSB:FOUR_DLY_LSB];

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // Host-mode pins keep the timer idle; output two stays live for termination
         run[i] = (mode[i] != PGD_MODE_HOST);
         if (i == 1 && two_drives_termination) begin
            run[i] = 1'b1;
         end
         if (mode[i] == PGD_MODE_SHIFT) begin
            start_ok[i] = run[i] & shift_s[i];
         end else begin
            start_ok[i] = run[i] & (&(rail_s | ~mask[i]));
         end
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_timer
      pgd_delay_timer pgd_delay_timer_i (
         .clk_sys(clk_sys),
         .rst(rst),
         .tick(tick),
         .start_ok(start_ok[g]),
         .code(code[g]),
         .good(timer_good[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin outputs and rail enables
   logic [2:0] pin_q;
   logic [2:0] pin_d;
   logic [4:0] en_q;
   logic [4:0] en_d;
   logic [3:0] want;
   logic term_req;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_d[i] = (mode[i] == PGD_MODE_HOST) ? host_level[i] : timer_good[i];
      end
      term_req = two_drives_termination ? timer_good[1] : rail_request[0];
      // Force-on lifts the rail; its off bit still has the last word
      want = rail_force_on | {rail_request[3:1], term_req};
      en_d[4] = off_q[SHARED_OFF_BIT] & want[3] & ~shared_selects_linear;
      en_d[3] = off_q[SHARED_OFF_BIT] & want[3] & shared_selects_linear;
      en_d[2] = off_q[FIRST_B_OFF_BIT] & want[2];
      en_d[1] = off_q[FIRST_A_OFF_BIT] & want[1];
      en_d[0] = off_q[TERM_OFF_BIT] & want[0];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_q <= 3'h0;
         en_q <= 5'h00;
      end else begin
         pin_q <= pin_d;
         en_q <= en_d;
      end
   end

   assign general_output_one = pin_q[0];
   assign general_output_two = pin_q[1];
   assign general_output_four = pin_q[2];
   assign second_b_load_switch_en = en_q[4];
   assign first_a_linear_regulator_en = en_q[3];
   assign first_b_load_switch_en = en_q[2];
   assign first_a_load_switch_en = en_q[1];
   assign memory_termination_regulator_en = en_q[0];

endmodule : pgd_top

/* testbench/pgd_top_monitor.sv */
// Checker for the power-good delay and rail disable top, bound by port name.
// Assumes straps and modes hold steady while the design is out of reset.
`timescale 1ns/1ps

module pgd_top_monitor
   import pgd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [7:0] rail_in_reg,
   input wire logic [7:0] group_mask_one,
   input wire logic [7:0] group_mask_two,
   input wire logic [7:0] group_mask_four,
   input wire logic [2:0] shifter_in,
   input wire logic [1:0] mode_one,
   input wire logic [1:0] mode_two,
   input wire logic [1:0] mode_four,
   input wire logic [2:0] host_level,
   input wire logic two_drives_termination,
   input wire logic shared_selects_linear,
   input wire logic [3:0] rail_request,
   input wire logic [3:0] rail_force_on,
   input wire logic general_output_one,
   input wire logic general_output_two,
   input wire logic general_output_four,
   input wire logic second_b_load_switch_en,
   input wire logic first_a_linear_regulator_en,
   input wire logic first_b_load_switch_en,
   input wire logic first_a_load_switch_en,
   input wire logic memory_termination_regulator_en
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////
   // Six cycles cover the input syncers plus the drop path
   sequence s_one_lost;
      ((rail_in_reg & group_mask_one) != group_mask_one) [*6];
   endsequence
   sequence s_two_idle;
      (!shifter_in[1]) [*6];
   endsequence

   a_reset_quiet: assert property (disable iff (1'b0)
      rst |=> !general_output_one && !general_output_two && !general_output_four)
      else $error("pin active after reset");
   a_one_drop: assert property ((mode_one == PGD_MODE_GOOD) throughout s_one_lost
      |-> !general_output_one)
      else $error("pin one high with rails out");
   // Rail sample to pin rise is four edges: two syncers, timer flop, pin flop
   a_one_cause: assert property (
      $rose(general_output_one) && mode_one == PGD_MODE_GOOD
      |-> $past((rail_in_reg & group_mask_one) == group_mask_one, 4))
      else $error("pin one rose without rails");
   a_two_shift: assert property ((mode_two == PGD_MODE_SHIFT) throughout s_two_idle
      |-> !general_output_two)
      else $error("shifter pin high with input low");
   a_four_host: assert property (mode_four == PGD_MODE_HOST && !$past(rst)
      |-> general_output_four == $past(host_level[2]))
      else $error("host pin not following level");

   ////////////////////////////////////////
   // Enables need a request or force one cycle earlier
   a_shared_b: assert property (second_b_load_switch_en
      |-> !$past(shared_selects_linear) && $past(rail_force_on[3] | rail_request[3]))
      else $error("shared switch on without cause");
   a_shared_lin: assert property (first_a_linear_regulator_en
      |-> $past(shared_selects_linear) && $past(rail_force_on[3] | rail_request[3]))
      else $error("linear regulator on without cause");
   a_first_b: assert property (first_b_load_switch_en
      |-> $past(rail_force_on[2] | rail_request[2]))
      else $error("first b switch on without cause");
   a_first_a: assert property (first_a_load_switch_en
      |-> $past(rail_force_on[1] | rail_request[1]))
      else $error("first a switch on without cause");
   a_term_cause: assert property (
      memory_termination_regulator_en && !two_drives_termination
      |-> $past(rail_force_on[0] | rail_request[0]))
      else $error("termination on without cause");
endmodule : pgd_top_monitor

bind pgd_top pgd_top_monitor pgd_top_monitor_i (.*);

/* testbench/pgd_host_model.sv */
// Two-wire bus host that reads and writes the block's registers.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps

module pgd_host_model (
   input wire logic clk_sys,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // Data moves mid-low phase so a clock fall never meets a data edge
   localparam int HALF = 10;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic gap();
      repeat (HALF) @(posedge clk_sys);
   endtask : gap

   task automatic bit_io(input logic b, output logic r);
      gap();
      sda_low <= !b;
      gap();
      scl <= 1'b1;
      gap();
      r = sda_line;
      scl <= 1'b0;
   endtask : bit_io

   task automatic start_cond();
      gap();
      sda_low <= 1'b0;
      gap();
      scl <= 1'b1;
      gap();
      sda_low <= 1'b1;
      gap();
      scl <= 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      gap();
      sda_low <= 1'b1;
      gap();
      scl <= 1'b1;
      gap();
      sda_low <= 1'b0;
      gap();
   endtask : stop_cond

   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
      output logic nak);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         q[i] = b;
      end
      bit_io(last, nak);
   endtask : byte_io

   task automatic write_reg(input logic [6:0] adr, input logic [7:0] p, input logic [7:0] d,
      output logic ok);
      logic [7:0] q;
      logic [2:0] n;
      start_cond();
      byte_io({adr, 1'b0}, 1'b1, q, n[0]);
      byte_io(p, 1'b1, q, n[1]);
      byte_io(d, 1'b1, q, n[2]);
      stop_cond();
      ok = (n === 3'b000);
   endtask : write_reg

   task automatic read_reg(input logic [6:0] adr, input logic [7:0] p, output logic [7:0] d,
      output logic ok);
      logic [7:0] q;
      logic [2:0] n;
      logic x;
      start_cond();
      byte_io({adr, 1'b0}, 1'b1, q, n[0]);
      byte_io(p, 1'b1, q, n[1]);
      start_cond();
      byte_io({adr, 1'b1}, 1'b1, q, n[2]);
      // No ack on the single data byte ends the read
      byte_io(8'hff, 1'b1, d, x);
      stop_cond();
      ok = (n === 3'b000);
   endtask : read_reg
endmodule : pgd_host_model

/* testbench/pgd_top_bench.sv */
// Self-checking bench for the power-good delay and rail disable block.
// Assumes the host model drives the bus and the checker is bound to the top.
`timescale 1ns/1ps

module pgd_top_bench
   import pgd_pkg::*;
();
   logic clk_sys, rst, scl_in, sda_in, sda_out, sda_oe, sda_low;
   logic two_drives_termination, shared_selects_linear;
   logic general_output_one, general_output_two, general_output_four;
   logic second_b_load_switch_en, first_a_linear_regulator_en, first_b_load_switch_en;
   logic first_a_load_switch_en, memory_termination_regulator_en;
   logic [7:0] rail_in_reg, group_mask_one, group_mask_two, group_mask_four;
   logic [3:0] rail_request, rail_force_on;
   logic [2:0] shifter_in, host_level;
   logic [1:0] mode_one, mode_two, mode_four;
   logic [4:0] en_vec;
   int err_count = 0;
   int num_checks = 0;

   assign sda_in = ~(sda_low | (sda_oe & ~sda_out));
   // Unselected shared rail sits in the top bit and must stay off
   assign en_vec = {shared_selects_linear ? second_b_load_switch_en : first_a_linear_regulator_en,
      shared_selects_linear ? first_a_linear_regulator_en : second_b_load_switch_en,
      first_b_load_switch_en, first_a_load_switch_en, memory_termination_regulator_en};

   pgd_top pgd_top_i (.*);
   pgd_host_model pgd_host_model_i (.clk_sys(clk_sys), .sda_line(sda_in), .scl(scl_in),
      .sda_low(sda_low));

   always #12.5 clk_sys = ~clk_sys;

   ////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask : chk

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic ok;
      pgd_host_model_i.write_reg(DEV_ADDR_DEFAULT, p, d, ok);
      chk({7'h00, ok}, 8'h01, "write not acked");
   endtask : wr

   task automatic rdchk(input logic [7:0] p, input logic [7:0] exp, input string msg);
      logic ok;
      logic [7:0] d;
      pgd_host_model_i.read_reg(DEV_ADDR_DEFAULT, p, d, ok);
      chk({7'h00, ok}, 8'h01, "read not acked");
      chk(d, exp, msg);
   endtask : rdchk

   task automatic wait_pin(ref logic s, input logic v, input int n, input string msg);
      repeat (n) begin
         @(negedge clk_sys);
         if (s === v) break;
      end
      chk({7'h00, s}, {7'h00, v}, msg);
   endtask : wait_pin

   ////////////////////////////////////////
   task automatic t_regs();
      logic ok;
      rdchk(OFF_GOOD_DELAY, RST_GOOD_DELAY, "delay reset value");
      rdchk(OFF_RAIL_OFF, RST_RAIL_OFF, "disable reset value");
      wr(OFF_GOOD_DELAY, 8'hb6);
      rdchk(OFF_GOOD_DELAY, 8'hb6, "delay readback");
      rdchk(8'h9e, 8'h00, "unmapped read");
      pgd_host_model_i.write_reg(7'h21, OFF_RAIL_OFF, 8'h00, ok);
      chk({7'h00, ok}, 8'h00, "foreign address acked");
      rdchk(OFF_RAIL_OFF, RST_RAIL_OFF, "foreign write landed");
      $display("test regs done");
   endtask : t_regs

   task automatic t_disable();
      logic [7:0] ev;
      for (int j = 0; j < 2; j++) begin
         @(posedge clk_sys);
         rail_request <= (j == 0) ? 4'hf : 4'h0;
         rail_force_on <= (j == 0) ? 4'h0 : 4'hf;
         shared_selects_linear <= (j == 1);
         for (int i = 0; i < 4; i++) begin
            wr(OFF_RAIL_OFF, RST_RAIL_OFF & ~(8'h10 << i));
            @(negedge clk_sys);
            ev = {4'h0, 4'hf & ~(4'h1 << i)};
            chk({3'h0, en_vec}, ev, "enables");
         end
      end
      @(posedge clk_sys);
      rail_force_on <= 4'h0;
      wr(OFF_RAIL_OFF, RST_RAIL_OFF);
      @(negedge clk_sys);
      chk({3'h0, en_vec}, 8'h00, "enable without request");
      $display("test disable done");
   endtask : t_disable

   task automatic t_delay();
      wr(OFF_GOOD_DELAY, 8'h00);
      @(posedge clk_sys);
      rail_in_reg <= 8'hfe;
      wait_pin(general_output_one, 1'b0, 8, "pin one kept");
      @(posedge clk_sys);
      rail_in_reg <= 8'hfb;
      wait_pin(general_output_one, 1'b1, 8, "pin one late");
      @(posedge clk_sys);
      shifter_in <= 3'h2;
      wait_pin(general_output_two, 1'b1, 8, "shifter pin late");
      @(posedge clk_sys);
      shifter_in <= 3'h0;
      rail_in_reg <= 8'hfd;
      wr(OFF_GOOD_DELAY, 8'hdd);
      @(posedge clk_sys);
      shifter_in <= 3'h2;
      rail_in_reg <= 8'hff;
      // A 5 ms delay is far beyond the run, so only an early rise is checked
      repeat (3000) @(negedge clk_sys);
      chk({7'h00, general_output_one}, 8'h00, "pin one early");
      chk({7'h00, general_output_two}, 8'h00, "pin two early");
      @(posedge clk_sys);
      host_level <= 3'h4;
      wait_pin(general_output_four, 1'b1, 4, "host pin high");
      @(posedge clk_sys);
      host_level <= 3'h0;
      wait_pin(general_output_four, 1'b0, 4, "host pin low");
      $display("test delay done");
   endtask : t_delay

   task automatic t_term();
      wr(OFF_GOOD_DELAY, 8'h00);
      @(posedge clk_sys);
      mode_two <= PGD_MODE_HOST;
      two_drives_termination <= 1'b1;
      host_level <= 3'h0;
      wait_pin(memory_termination_regulator_en, 1'b1, 8, "term off");
      chk({7'h00, general_output_two}, 8'h00, "pin two not host");
      @(posedge clk_sys);
      rail_in_reg <= 8'hf7;
      wait_pin(memory_termination_regulator_en, 1'b0, 8, "term kept");
      $display("test term done");
   endtask : t_term

   ////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      $display("wrong value at %0t ns: run hung", $time);
      end_sim();
   end

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      rail_in_reg = 8'hff;
      group_mask_one = 8'h03;
      group_mask_two = 8'h0c;
      group_mask_four = 8'h30;
      shifter_in = 3'h0;
      mode_one = PGD_MODE_GOOD;
      mode_two = PGD_MODE_SHIFT;
      mode_four = PGD_MODE_HOST;
      host_level = 3'h0;
      two_drives_termination = 1'b0;
      shared_selects_linear = 1'b0;
      rail_request = 4'hf;
      rail_force_on = 4'h0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      t_regs();
      t_disable();
      t_delay();
      t_term();
      end_sim();
   end
endmodule : pgd_top_bench
